/* logic/dual_byte_timer_pwm_unit_params.svh */
// Constants for the dual byte timer and PWM unit: register indices,
// reset values and fixed counts.
// Assumes inclusion by the package and the testbench only.
`ifndef DUAL_BYTE_TIMER_PWM_UNIT_PARAMS_SVH
`define DUAL_BYTE_TIMER_PWM_UNIT_PARAMS_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define IDX_TIMER_CONTROL 16'hfe18
`define IDX_PRESCALE_SELECT 16'hfe19
`define IDX_LOW_COUNT_VALUE 16'hfe1a
`define IDX_HIGH_COUNT_VALUE 16'hfe1b
`define IDX_LOW_MATCH_DATA 16'hfe1c
`define IDX_HIGH_MATCH_DATA 16'hfe1d
`define IDX_EVENT_SELECT 16'hfe1e

// -----------------------------------------------------------------
// Reset values and fixed counts
// -----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_EVSEL 2'h0
`define EVSEL_NONE 2'h0
`define BYTE_TOP 8'hff
`define BYTE_ZERO 8'h00
`define PRESC_BASE 9'h002
`define PRESC_ONE 9'h001

`endif

/* logic/dual_byte_timer_pwm_unit_pkg.sv */
// Types shared by the dual byte timer and PWM unit.
// Assumes the params header sits beside it.
package dual_byte_timer_pwm_unit_pkg;
  `include "dual_byte_timer_pwm_unit_params.svh"

  // -----------------------------------------------------------------
  // Register layouts
  // -----------------------------------------------------------------
  typedef struct packed {
    logic high_run_bit;
    logic low_run_bit;
    logic cascade_bit;
    logic pwm_mode_bit;
    logic high_match_flag;
    logic high_irq_enable;
    logic low_match_flag;
    logic low_irq_enable;
  } timer_control_t;

  typedef struct packed {
    logic high_prescale_enable;
    logic [2:0] high_prescale_code;
    logic low_prescale_enable;
    logic [2:0] low_prescale_code;
  } prescale_select_t;

  typedef struct packed {
    logic prescale_enable;
    logic [2:0] prescale_code;
  } prescale_half_t;
endpackage

/* logic/dual_byte_timer_pwm_unit.sv */
// Dual byte timer/counter with toggle and PWM outputs, APB slave.
// Assumes an APB master on pclk and event pins that are asynchronous.
//
// Overview of operation
// - Low prescaler input: 2 cycles/events, or 1 cycle
// - High prescaler input: 2, 1, low match, low period
// - Selected event pin makes low byte count events
// - Prescale divides 1, or 2 to 256 by code
// - Prescaler cleared on stop or byte reset
// - Run bits 6 and 7 start each byte
// - Low counter matches buffer, clears unless PWM
// - High counter matches buffer, clears except mode 1
// - Buffer follows data stopped, loads at zero running
// - Low output high stopped, low when data FFH
// - High output high stopped, low when data FFH
// - PWM bit 0 toggles low output on match
// - Low PWM: clear on overflow, set on match
// - Toggle high output unless PWM without cascade
// - High PWM: clear on overflow, set on match
// - Mode 1 PWM period 256 prescale counts
// - Mode 0 period (match+1) times prescale times two
// - Mode 2 high byte counts low byte periods
// - Mode 3 high byte counts low PWM periods
// - One interrupt request per enabled counter period
// - Stopped counter holds zero
// - Match flag sets at zero, software clears
// - Flag and enable both set raise request
`timescale 1ns/100ps

module dual_byte_timer_pwm_unit
  import dual_byte_timer_pwm_unit_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_pin_a,
  input wire logic event_pin_b,
  output logic low_output,
  output logic high_output,
  output logic timer_irq
);

  // -----------------------------------------------------------------
  // Registers and shared signals
  // -----------------------------------------------------------------
  timer_control_t ctrl_ff;
  prescale_select_t presc_ff;
  prescale_half_t low_pset_ff, high_pset_ff;
  logic [31:0] prdata_ff;
  logic [7:0] low_match_data_ff, high_match_data_ff, low_counter_ff, high_counter_ff;
  logic [7:0] low_buf_ff, high_buf_ff, low_pcnt_ff, high_pcnt_ff;
  logic [2:0] ev_a_ff, ev_b_ff;
  logic [1:0] event_pin_select_ff;
  logic pready_ff, pslverr_ff, low_output_ff, high_output_ff, timer_irq_ff, half_ff;

  logic [15:0] idx;
  logic [7:0] rd_byte, low_last, high_last, nxt_low_counter, nxt_high_counter;
  logic wr_en, mapped, half_tick, ev_edge, low_in_tick, high_in_tick;
  logic low_tick, high_tick, low_hit, high_hit, low_ovf, high_ovf;
  logic low_clr_mode, high_clr_mode, high_pwm_mode;
  logic low_wrap, high_wrap, nxt_low_flag, nxt_high_flag;

  default clocking cb_check @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign low_output = low_output_ff;
  assign high_output = high_output_ff;
  assign timer_irq = timer_irq_ff;

  // Last prescaler state for a division of 1, or 2 << code
  function automatic logic [7:0] presc_last(input prescale_half_t p);
    logic [8:0] n;
    n = p.prescale_enable ? (`PRESC_BASE << p.prescale_code) : `PRESC_ONE;
    presc_last = 8'(n - `PRESC_ONE);
  endfunction

  // -----------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------
  // Answer is prepared in the setup cycle so that every bus output is a
  // flop; the access phase therefore never waits.
  assign idx = paddr[ADDR_W-1:2];
  assign wr_en = psel & penable & pwrite & pready_ff;

  always_comb begin
    mapped = 1'b1;
    rd_byte = `RST_BYTE;
    case (idx)
      `IDX_TIMER_CONTROL: rd_byte = ctrl_ff;
      `IDX_PRESCALE_SELECT: rd_byte = presc_ff;
      `IDX_LOW_COUNT_VALUE: rd_byte = low_counter_ff;
      `IDX_HIGH_COUNT_VALUE: rd_byte = high_counter_ff;
      `IDX_LOW_MATCH_DATA: rd_byte = low_match_data_ff;
      `IDX_HIGH_MATCH_DATA: rd_byte = high_match_data_ff;
      `IDX_EVENT_SELECT: rd_byte = {6'h00, event_pin_select_ff};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~mapped;
      prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= `RST_BYTE;
      low_match_data_ff <= `RST_BYTE;
      high_match_data_ff <= `RST_BYTE;
      event_pin_select_ff <= `RST_EVSEL;
    end else if (wr_en) begin
      if (idx == `IDX_PRESCALE_SELECT) begin
        presc_ff <= pwdata[7:0];
      end
      if (idx == `IDX_LOW_MATCH_DATA) begin
        low_match_data_ff <= pwdata[7:0];
      end
      if (idx == `IDX_HIGH_MATCH_DATA) begin
        high_match_data_ff <= pwdata[7:0];
      end
      if (idx == `IDX_EVENT_SELECT) begin
        event_pin_select_ff <= pwdata[1:0];
      end
    end
  end

  // Flags: writing 0 clears, writing 1 keeps; a hardware set wins
  always_comb begin
    nxt_low_flag = ctrl_ff.low_match_flag;
    nxt_high_flag = ctrl_ff.high_match_flag;
    if (wr_en && idx == `IDX_TIMER_CONTROL) begin
      nxt_low_flag = ctrl_ff.low_match_flag & pwdata[1];
      nxt_high_flag = ctrl_ff.high_match_flag & pwdata[3];
    end
    nxt_low_flag = nxt_low_flag | low_wrap;
    nxt_high_flag = nxt_high_flag | high_wrap;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `RST_BYTE;
    end else begin
      if (wr_en && idx == `IDX_TIMER_CONTROL) begin
        ctrl_ff.high_run_bit <= pwdata[7];
        ctrl_ff.low_run_bit <= pwdata[6];
        ctrl_ff.cascade_bit <= pwdata[5];
        ctrl_ff.pwm_mode_bit <= pwdata[4];
        ctrl_ff.high_irq_enable <= pwdata[2];
        ctrl_ff.low_irq_enable <= pwdata[0];
      end
      ctrl_ff.low_match_flag <= nxt_low_flag;
      ctrl_ff.high_match_flag <= nxt_high_flag;
    end
  end

  // -----------------------------------------------------------------
  // Clock sources: half rate tick and synchronised event pins
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= 1'b0;
      ev_a_ff <= 3'h0;
      ev_b_ff <= 3'h0;
    end else begin
      half_ff <= ~half_ff;
      ev_a_ff <= {ev_a_ff[1:0], event_pin_a};
      ev_b_ff <= {ev_b_ff[1:0], event_pin_b};
    end
  end

  assign half_tick = half_ff;
  // Rising edges only; stage 0 of each chain is never looked at
  assign ev_edge = (event_pin_select_ff[0] & ev_a_ff[1] & ~ev_a_ff[2])
                 | (event_pin_select_ff[1] & ev_b_ff[1] & ~ev_b_ff[2]);

  // Event counting is undefined with PWM mode set; PWM takes the cycle clock
  always_comb begin
    if (ctrl_ff.pwm_mode_bit) begin
      low_in_tick = 1'b1;
    end else if (event_pin_select_ff != `EVSEL_NONE) begin
      low_in_tick = ev_edge;
    end else begin
      low_in_tick = half_tick;
    end
  end

  always_comb begin
    case ({ctrl_ff.cascade_bit, ctrl_ff.pwm_mode_bit})
      2'b00: high_in_tick = half_tick;
      2'b01: high_in_tick = 1'b1;
      2'b10: high_in_tick = low_hit;
      2'b11: high_in_tick = low_ovf;
      default: high_in_tick = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Prescalers
  // -----------------------------------------------------------------
  assign low_last = presc_last(low_pset_ff);
  assign high_last = presc_last(high_pset_ff);
  assign low_tick = ctrl_ff.low_run_bit & low_in_tick & (low_pcnt_ff == low_last);
  assign high_tick = ctrl_ff.high_run_bit & high_in_tick & (high_pcnt_ff == high_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_pcnt_ff <= `BYTE_ZERO;
    end else if (!ctrl_ff.low_run_bit || low_tick) begin
      low_pcnt_ff <= `BYTE_ZERO;
    end else if (low_in_tick) begin
      low_pcnt_ff <= low_pcnt_ff + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_pcnt_ff <= `BYTE_ZERO;
    end else if (!ctrl_ff.high_run_bit || high_tick) begin
      high_pcnt_ff <= `BYTE_ZERO;
    end else if (high_in_tick) begin
      high_pcnt_ff <= high_pcnt_ff + 8'h01;
    end
  end

  // -----------------------------------------------------------------
  // Byte counters
  // -----------------------------------------------------------------
  assign low_clr_mode = ~ctrl_ff.pwm_mode_bit;
  assign high_pwm_mode = ctrl_ff.pwm_mode_bit & ~ctrl_ff.cascade_bit;
  assign high_clr_mode = ~high_pwm_mode;
  assign low_hit = low_tick & (low_counter_ff == low_buf_ff);
  assign high_hit = high_tick & (high_counter_ff == high_buf_ff);
  assign low_ovf = low_tick & (low_counter_ff == `BYTE_TOP);
  assign high_ovf = high_tick & (high_counter_ff == `BYTE_TOP);
  assign nxt_low_counter = (low_hit && low_clr_mode) ? `BYTE_ZERO : low_counter_ff + 8'h01;
  assign nxt_high_counter = (high_hit && high_clr_mode) ? `BYTE_ZERO : high_counter_ff + 8'h01;
  // One wrap to zero per period drives flag, buffer reload and request
  assign low_wrap = low_tick & (nxt_low_counter == `BYTE_ZERO);
  assign high_wrap = high_tick & (nxt_high_counter == `BYTE_ZERO);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_counter_ff <= `BYTE_ZERO;
    end else if (!ctrl_ff.low_run_bit) begin
      low_counter_ff <= `BYTE_ZERO;
    end else if (low_tick) begin
      low_counter_ff <= nxt_low_counter;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_counter_ff <= `BYTE_ZERO;
    end else if (!ctrl_ff.high_run_bit) begin
      high_counter_ff <= `BYTE_ZERO;
    end else if (high_tick) begin
      high_counter_ff <= nxt_high_counter;
    end
  end

  // Prescale changes take hold at the same moment as the match buffer,
  // so a running period is never cut short by a new code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_buf_ff <= `BYTE_ZERO;
      low_pset_ff <= 4'h0;
    end else if (!ctrl_ff.low_run_bit || low_wrap) begin
      low_buf_ff <= low_match_data_ff;
      low_pset_ff <= {presc_ff.low_prescale_enable, presc_ff.low_prescale_code};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_buf_ff <= `BYTE_ZERO;
      high_pset_ff <= 4'h0;
    end else if (!ctrl_ff.high_run_bit || high_wrap) begin
      high_buf_ff <= high_match_data_ff;
      high_pset_ff <= {presc_ff.high_prescale_enable, presc_ff.high_prescale_code};
    end
  end

  // -----------------------------------------------------------------
  // Outputs and interrupt request
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_output_ff <= 1'b1;
    end else if (!ctrl_ff.low_run_bit) begin
      low_output_ff <= 1'b1;
    end else if (low_match_data_ff == `BYTE_TOP) begin
      low_output_ff <= 1'b0;
    end else if (!ctrl_ff.pwm_mode_bit) begin
      low_output_ff <= low_output_ff ^ low_hit;
    end else if (low_hit) begin
      low_output_ff <= 1'b1;
    end else if (low_ovf) begin
      low_output_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_output_ff <= 1'b1;
    end else if (!ctrl_ff.high_run_bit) begin
      high_output_ff <= 1'b1;
    end else if (high_match_data_ff == `BYTE_TOP) begin
      high_output_ff <= 1'b0;
    end else if (!high_pwm_mode) begin
      high_output_ff <= high_output_ff ^ high_hit;
    end else if (high_hit) begin
      high_output_ff <= 1'b1;
    end else if (high_ovf) begin
      high_output_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_ff <= 1'b0;
    end else begin
      timer_irq_ff <= (ctrl_ff.low_match_flag & ctrl_ff.low_irq_enable)
                    | (ctrl_ff.high_match_flag & ctrl_ff.high_irq_enable);
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  // The output follows the control state of the hit cycle, so a stop
  // written right after a hit must not matter here.
  sequence s_low_live_hit;
    low_hit && ctrl_ff.low_run_bit && low_match_data_ff != `BYTE_TOP;
  endsequence
  sequence s_low_set_next;
    ##1 low_output_ff;
  endsequence

  property p_low_stop_zero;
    !ctrl_ff.low_run_bit |=> low_counter_ff == `BYTE_ZERO && low_pcnt_ff == `BYTE_ZERO;
  endproperty
  a_low_stop_zero: assert property (p_low_stop_zero)
    else $error("low counter not zero while stopped");
  property p_low_stop_high;
    !ctrl_ff.low_run_bit |=> low_output_ff;
  endproperty
  a_low_stop_high: assert property (p_low_stop_high)
    else $error("low output not high while stopped");
  property p_high_ff_low;
    ctrl_ff.high_run_bit && high_match_data_ff == `BYTE_TOP |=> !high_output_ff;
  endproperty
  a_high_ff_low: assert property (p_high_ff_low)
    else $error("high output not low with top match data");
  property p_low_toggle;
    s_low_live_hit and !ctrl_ff.pwm_mode_bit |=> low_output_ff != $past(low_output_ff);
  endproperty
  a_low_toggle: assert property (p_low_toggle)
    else $error("low output did not toggle on match");
  property p_low_pwm_set;
    s_low_live_hit and ctrl_ff.pwm_mode_bit |-> s_low_set_next;
  endproperty
  a_low_pwm_set: assert property (p_low_pwm_set)
    else $error("low PWM output not set on match");
  property p_low_flag_set;
    low_wrap |=> ctrl_ff.low_match_flag ##1 (timer_irq_ff || !$past(ctrl_ff.low_irq_enable));
  endproperty
  a_low_flag_set: assert property (p_low_flag_set)
    else $error("low flag or request missing after wrap");
  property p_irq_flag;
    ctrl_ff.high_match_flag && ctrl_ff.high_irq_enable |=> timer_irq_ff;
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("request missing with high flag enabled");
  property p_presc_bound;
    low_pcnt_ff <= low_last && high_pcnt_ff <= high_last;
  endproperty
  a_presc_bound: assert property (p_presc_bound)
    else $error("prescaler beyond its division");
  property p_buf_follow;
    !ctrl_ff.high_run_bit |=> high_buf_ff == $past(high_match_data_ff);
  endproperty
  a_buf_follow: assert property (p_buf_follow)
    else $error("high buffer did not follow match data");
  property p_high_clear;
    high_hit && high_clr_mode && ctrl_ff.high_run_bit |=> high_counter_ff == `BYTE_ZERO;
  endproperty
  a_high_clear: assert property (p_high_clear)
    else $error("high counter not cleared on match");

endmodule

/* sim/testbench.sv */
// Self-checking bench for the dual byte timer and PWM unit over APB.
// Assumes the design package and params header are compiled first.
`timescale 1ns/100ps
`include "dual_byte_timer_pwm_unit_params.svh"

module testbench;
  logic pclk = '0;
  logic presetn = '0;
  logic psel = '0;
  logic penable = '0;
  logic pwrite = '0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic event_pin_a = '0;
  logic event_pin_b = '0;
  logic look_req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, low_output, high_output, timer_irq;
  int failures = 0;
  int checks_done = 0;
  int ev_cnt = 0;
  int cnt[2];
  logic prv[2];
  int iq[2][$];
  logic [33:0] rd_q[$];
  logic [5:0] lv_q[$];
  logic [7:0] rl, rh;

  always #10 pclk = ~pclk;

  dual_byte_timer_pwm_unit #(.ADDR_W(18)) dual_byte_timer_pwm_unit_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .event_pin_a,
    .event_pin_b, .low_output, .high_output, .timer_irq);

  // -----------------------------------------------------------------
  // Event pins: two different rates, so the selected pin is visible
  // -----------------------------------------------------------------
  always @(posedge pclk) begin
    ev_cnt <= ev_cnt + 1;
    event_pin_a <= (ev_cnt % 10) < 5;
    event_pin_b <= (ev_cnt % 14) < 7;
  end

  // -----------------------------------------------------------------
  // Compare tasks and verdict
  // -----------------------------------------------------------------
  task automatic tally(input logic ok, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (!ok) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
    tally(g === e, e, g);
  endtask

  task automatic cmp_int(input int e, input int g);
    tally(g == e, e, g);
  endtask

  task automatic cmp_lvl(input logic [5:0] e, input logic [2:0] g);
    tally((g & e[5:3]) === e[2:0], e[2:0], g & e[5:3]);
  endtask

  task automatic report_and_stop;
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic outp(input int i);
    return i ? high_output : low_output;
  endfunction

  // -----------------------------------------------------------------
  // Result watcher: pops the oldest note when a result shows up
  // -----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1)
      cmp_bus(rd_q.pop_front(), {pwrite, pslverr, pwrite ? 32'h0 : prdata});
    if (look_req)
      cmp_lvl(lv_q.pop_front(), {low_output, high_output, timer_irq});
    for (int i = 0; i < 2; i++) begin
      if (outp(i) !== prv[i]) begin
        if (iq[i].size() > 0)
          cmp_int(iq[i].pop_front(), cnt[i]);
        cnt[i] = 1;
      end else
        cnt[i] = cnt[i] + 1;
      prv[i] = outp(i);
    end
  end

  // -----------------------------------------------------------------
  // Drivers
  // -----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                     input logic err = 1'h0);
    @(posedge pclk);
    rd_q.push_back({wr, err, 24'h0, (wr | err) ? 8'h00 : d});
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'($urandom), d};
    penable <= 1'h0;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic look(input logic [2:0] m, input logic [2:0] v);
    @(posedge pclk);
    lv_q.push_back({m, v});
    look_req <= 1'h1;
    @(posedge pclk);
    look_req <= 1'h0;
  endtask

  // Phase a starts at a falling edge of the output, phase b follows
  task automatic meas(input int i, input int a, input int b, input int reps);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (outp(i) !== 1'h1 && n < 3000);
    do begin
      @(posedge pclk);
      n++;
    end while (outp(i) !== 1'h0 && n < 6000);
    #1;
    repeat (reps) begin
      iq[i].push_back(a);
      iq[i].push_back(b);
    end
    do begin
      @(posedge pclk);
      n++;
    end while (iq[i].size() > 0 && n < 9000);
    if (iq[i].size() > 0) begin
      failures++;
      report_and_stop;
    end
    iq[i].delete();
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'hde451572));
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    look(3'h7, 3'h6);
    for (int a = 'hfe18; a <= 'hfe1d; a++) apb(1'h0, 16'(a), 8'h00);
    apb(1'h0, 16'hfe20, 8'h00, 1'h1);
    apb(1'h1, 16'hfe20, 8'h5a, 1'h1);
    rl = 8'($urandom % 255);
    rh = 8'($urandom % 255);
    apb(1'h1, `IDX_LOW_COUNT_VALUE, 8'h55);
    apb(1'h0, `IDX_LOW_COUNT_VALUE, 8'h00);
    // Every prescale code on the high byte in toggle mode, match 0
    for (int k = 0; k <= 8; k++) begin
      apb(1'h1, `IDX_PRESCALE_SELECT, k == 8 ? 8'h00 : {1'h1, k[2:0], 4'h0});
      apb(1'h1, `IDX_TIMER_CONTROL, 8'h80);
      meas(1, k == 8 ? 2 : 4 << k, k == 8 ? 2 : 4 << k, 2);
      apb(1'h0, `IDX_TIMER_CONTROL, 8'h88);
      apb(1'h1, `IDX_TIMER_CONTROL, 8'h00);
    end
    // Two PWMs, low prescale 2, high prescale 1
    apb(1'h1, `IDX_LOW_MATCH_DATA, rl);
    apb(1'h1, `IDX_HIGH_MATCH_DATA, rh);
    apb(1'h1, `IDX_PRESCALE_SELECT, 8'h08);
    apb(1'h0, `IDX_HIGH_MATCH_DATA, rh);
    apb(1'h1, `IDX_TIMER_CONTROL, 8'hd0);
    meas(0, (rl + 1) * 2, 512 - (rl + 1) * 2, 2);
    meas(1, rh + 1, 255 - rh, 2);
    apb(1'h1, `IDX_LOW_MATCH_DATA, 8'hff);
    apb(1'h1, `IDX_HIGH_MATCH_DATA, 8'hff);
    look(3'h6, 3'h0);
    apb(1'h1, `IDX_TIMER_CONTROL, 8'h00);
    look(3'h6, 3'h6);
    apb(1'h0, `IDX_HIGH_COUNT_VALUE, 8'h00);
    // Cascade: high half period 2 * 1 * 3 * 2 * 2 cycles
    apb(1'h1, `IDX_LOW_MATCH_DATA, 8'h02);
    apb(1'h1, `IDX_HIGH_MATCH_DATA, 8'h01);
    apb(1'h1, `IDX_TIMER_CONTROL, 8'he0);
    meas(1, 24, 24, 2);
    meas(0, 12, 12, 1);
    // Long timer with low PWM, then a match change while running
    apb(1'h1, `IDX_TIMER_CONTROL, 8'h00);
    apb(1'h1, `IDX_PRESCALE_SELECT, 8'h00);
    apb(1'h1, `IDX_HIGH_MATCH_DATA, 8'h00);
    apb(1'h1, `IDX_LOW_MATCH_DATA, rl);
    apb(1'h1, `IDX_TIMER_CONTROL, 8'hf0);
    meas(1, 256, 256, 1);
    meas(0, rl + 1, 255 - rl, 1);
    apb(1'h1, `IDX_LOW_MATCH_DATA, rh);
    meas(0, rh + 1, 255 - rh, 1);
    // Low byte on the half-rate clock, then on each event pin
    apb(1'h1, `IDX_TIMER_CONTROL, 8'h00);
    apb(1'h1, `IDX_LOW_MATCH_DATA, 8'h01);
    apb(1'h1, `IDX_TIMER_CONTROL, 8'h40);
    meas(0, 4, 4, 1);
    for (int p = 1; p <= 2; p++) begin
      apb(1'h1, `IDX_TIMER_CONTROL, 8'h00);
      apb(1'h1, `IDX_EVENT_SELECT, 8'(p));
      apb(1'h1, `IDX_TIMER_CONTROL, 8'h40);
      meas(0, p == 1 ? 20 : 28, p == 1 ? 20 : 28, 2);
    end
    // Flag, mask, request and clear
    apb(1'h1, `IDX_TIMER_CONTROL, 8'h00);
    apb(1'h1, `IDX_EVENT_SELECT, 8'h00);
    apb(1'h1, `IDX_LOW_MATCH_DATA, 8'h00);
    apb(1'h1, `IDX_TIMER_CONTROL, 8'h40);
    repeat (8) @(posedge pclk);
    apb(1'h0, `IDX_TIMER_CONTROL, 8'h42);
    look(3'h1, 3'h0);
    apb(1'h1, `IDX_TIMER_CONTROL, 8'h03);
    look(3'h1, 3'h1);
    apb(1'h1, `IDX_TIMER_CONTROL, 8'h01);
    look(3'h1, 3'h0);
    apb(1'h0, `IDX_TIMER_CONTROL, 8'h01);
    report_and_stop;
  end

  // Hang guard, well beyond the expected run of about 10000 cycles
  initial begin
    #1000000;
    failures++;
    report_and_stop;
  end
endmodule
